// ===== design/pll_ref_sel_map.vh
// register offsets, reset values, mode and field codes for the reference selector
`ifndef PLL_REF_SEL_MAP_VH
`define PLL_REF_SEL_MAP_VH
`define ADDR_BASE_MULT_HI 8'h2A
`define ADDR_BASE_MULT_LO 8'h2B
`define ADDR_FEC_B3 8'h2C
`define ADDR_FEC_B2 8'h2D
`define ADDR_FEC_B1 8'h2E
`define ADDR_FEC_B0 8'h2F
`define ADDR_FILTER_CTRL 8'h30
`define ADDR_PRIO_23 8'h31
`define ADDR_PRIO_01 8'h32
`define ADDR_MODE_SEL 8'h33
`define ADDR_FAIL_MASK 8'h34
`define RST_BASE_MULT 16'h01E6
`define RST_FEC_RATIO 32'h00010001
`define RST_FILTER_CTRL 8'h0C
`define RST_PRIO_23 8'h32
`define RST_PRIO_01 8'h10
`define RST_MODE_SEL 8'h0F
`define RST_FAIL_MASK 8'h87
`define MODE_FREERUN 2'h0
`define MODE_HOLDOVER 2'h1
`define MODE_FORCED 2'h2
`define MODE_AUTO 2'h3
`define RANK_DISABLED 3'h7
`define BW_VARIABLE 3'h7
`endif

// ===== design/pll_reference_selector.v
// first loop reference selection and configuration register block
//
// Overview of operation
// - reference three multiplier is a 16-bit unsigned register field
// - frequency product base x multiplier x numerator offered out, denominator not applied
// - bits 3:2 choose phase slope cap, 11 means unlimited
// - bit 4 high requests phase realignment to the reference
// - bits 7:5 choose loop bandwidth code 000 to 110
// - bandwidth code 111 defers to the variable bandwidth setting
// - three-bit rank per reference, 111 disables it
// - different ranks switch revertively to lowest available rank
// - equal ranks never switch back to another available reference
// - bits 1:0 choose freerun, holdover, forced or automatic mode
// - automatic mode holds over only when no reference is available
// - forced mode locks programmed reference or holds over, never switches
// - forced holdover ignores references, keeps the last selection
// - freerun runs from local oscillator only
// - bit 5 enables external feedback delay compensation
// - the single feedback phase is used whichever loop computes it
// - bits 7:6 show choice in automatic mode, set it in forced mode
// - holdover mask bits 3:0 low block holdover on that failure
// - switch mask bits 7:4 low block switching on that failure
`include "pll_ref_sel_map.vh"
`default_nettype none
module pll_reference_selector (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // byte register port
    input wire reg_wr,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // failure flags per reference, four causes each, from monitor pins
    input wire [3:0] fail_signal_loss,
    input wire [3:0] fail_single_cycle_monitor,
    input wire [3:0] fail_coarse_frequency_monitor,
    input wire [3:0] fail_guard_soak_timer,
    // external
    input wire [15:0] base_freq_value,
    input wire [7:0] variable_bandwidth_setting,
    // loop controls
    output reg [1:0] phase_slope_cap,
    output reg phase_realign_enable,
    output reg [7:0] bandwidth_code,
    output reg feedback_compensation_enable,
    output reg track_reference,
    output reg holdover_active,
    output reg freerun_active,
    output reg [1:0] active_reference,
    output reg [63:0] ref_three_freq_product
);
    reg [15:0] base_multiplier_reg;
    reg [31:0] fec_ratio_reg;
    reg [7:0] filter_ctrl_reg;
    reg [7:0] prio_23_reg;
    reg [7:0] prio_01_reg;
    reg [7:0] mode_sel_reg;
    reg [7:0] fail_mask_reg;
    reg [1:0] sel_reg;
    reg [1:0] sel_next;
    reg hold_next;
    // three-stage sync per flag; stage two and three must agree
    reg [15:0] s1_reg, s2_reg, s3_reg, fail_reg;
    wire [15:0] fail_raw = {fail_guard_soak_timer,
        fail_coarse_frequency_monitor, fail_single_cycle_monitor,
        fail_signal_loss};
    wire [15:0] fec_numerator = fec_ratio_reg[31:16];
    wire [15:0] fec_denominator = fec_ratio_reg[15:0];
    wire [1:0] operating_mode_select = mode_sel_reg[1:0];
    wire [3:0] holdover_cause_mask = fail_mask_reg[3:0];
    wire [3:0] switch_cause_mask = fail_mask_reg[7:4];
    wire [11:0] ranks = {prio_23_reg[6:4], prio_23_reg[2:0],
        prio_01_reg[6:4], prio_01_reg[2:0]};
    wire [3:0] hold_fail;
    wire [3:0] sw_fail;
    wire [3:0] enabled;
    wire [3:0] avail_w;
    reg [7:0] rdata_next;
    reg [31:0] base_mult_prod_reg;
    // write strobes, one per byte lane
    wire wr_mult_hi = reg_wr && reg_addr == `ADDR_BASE_MULT_HI;
    wire wr_mult_lo = reg_wr && reg_addr == `ADDR_BASE_MULT_LO;
    wire wr_fec_b3 = reg_wr && reg_addr == `ADDR_FEC_B3;
    wire wr_fec_b2 = reg_wr && reg_addr == `ADDR_FEC_B2;
    wire wr_fec_b1 = reg_wr && reg_addr == `ADDR_FEC_B1;
    wire wr_fec_b0 = reg_wr && reg_addr == `ADDR_FEC_B0;
    wire wr_filter = reg_wr && reg_addr == `ADDR_FILTER_CTRL;
    wire wr_prio_23 = reg_wr && reg_addr == `ADDR_PRIO_23;
    wire wr_prio_01 = reg_wr && reg_addr == `ADDR_PRIO_01;
    wire wr_mode = reg_wr && reg_addr == `ADDR_MODE_SEL;
    wire wr_mask = reg_wr && reg_addr == `ADDR_FAIL_MASK;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : per_ref
            wire [3:0] causes = {fail_reg[12 + g], fail_reg[8 + g],
                fail_reg[4 + g], fail_reg[g]};
            wire [2:0] rank = ranks[3 * g +: 3];
            assign enabled[g] = rank != `RANK_DISABLED;
            assign hold_fail[g] = |(causes & holdover_cause_mask);
            assign sw_fail[g] = |(causes & switch_cause_mask);
            // a masked switch cause leaves the reference usable
            assign avail_w[g] = !sw_fail[g] && enabled[g];
        end
    endgenerate

    always @(posedge ref_clk) begin
        if (rst) begin
            s1_reg <= 16'h0000;
            s2_reg <= 16'h0000;
            s3_reg <= 16'h0000;
            fail_reg <= 16'h0000;
        end else begin
            s1_reg <= fail_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            fail_reg <= (s2_reg & s3_reg) | (fail_reg & (s2_reg | s3_reg));
        end
    end

    // reference selection
    integer i;
    reg [2:0] best_rank;
    reg [2:0] cand_rank;
    reg cur_ok;
    always @* begin
        sel_next = sel_reg;
        hold_next = 1'h0;
        best_rank = `RANK_DISABLED;
        cand_rank = `RANK_DISABLED;
        cur_ok = 1'h0;
        case (operating_mode_select)
            `MODE_AUTO: begin
                cur_ok = avail_w[sel_reg];
                // equal rank keeps current; lower rank takes over
                if (cur_ok) begin
                    best_rank = ranks[3 * sel_reg +: 3];
                end
                // strict compare, so the current reference, else the lowest index, wins a tie
                for (i = 0; i < 4; i = i + 1) begin
                    cand_rank = ranks[3 * i +: 3];
                    if (avail_w[i] && cand_rank < best_rank) begin
                        best_rank = cand_rank;
                        sel_next = i[1:0];
                    end
                end
                // holdover only with no reference available and a holdover cause on the selection
                hold_next = !(|avail_w) && hold_fail[sel_next];
            end
            `MODE_FORCED: begin
                sel_next = mode_sel_reg[7:6];
                hold_next = hold_fail[sel_next];
            end
            `MODE_HOLDOVER: begin
                // selection kept, so holdover rests on the last reference
                hold_next = 1'h1;
            end
            default: begin
                hold_next = 1'h0;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            sel_reg <= 2'h3;
        end else begin
            sel_reg <= sel_next;
        end
    end

    // each byte lane written on its own, high byte at the lower address
    always @(posedge ref_clk) begin
        if (rst) begin
            base_multiplier_reg <= `RST_BASE_MULT;
        end else begin
            if (wr_mult_hi) base_multiplier_reg[15:8] <= reg_wdata;
            if (wr_mult_lo) base_multiplier_reg[7:0] <= reg_wdata;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            fec_ratio_reg <= `RST_FEC_RATIO;
        end else begin
            if (wr_fec_b3) fec_ratio_reg[31:24] <= reg_wdata;
            if (wr_fec_b2) fec_ratio_reg[23:16] <= reg_wdata;
            if (wr_fec_b1) fec_ratio_reg[15:8] <= reg_wdata;
            if (wr_fec_b0) fec_ratio_reg[7:0] <= reg_wdata;
        end
    end

    // reserved low bits keep their reset pattern of zero
    always @(posedge ref_clk) begin
        if (rst) begin
            filter_ctrl_reg <= `RST_FILTER_CTRL;
        end else if (wr_filter) begin
            filter_ctrl_reg <= {reg_wdata[7:2], 2'h0};
        end
    end

    // bits 3 and 7 reserved, read as zero
    always @(posedge ref_clk) begin
        if (rst) begin
            prio_23_reg <= `RST_PRIO_23;
            prio_01_reg <= `RST_PRIO_01;
        end else begin
            if (wr_prio_23) prio_23_reg <= reg_wdata & 8'h77;
            if (wr_prio_01) prio_01_reg <= reg_wdata & 8'h77;
        end
    end

    // reserved bits 4:2 pinned at their reset value
    always @(posedge ref_clk) begin
        if (rst) begin
            mode_sel_reg <= `RST_MODE_SEL;
        end else if (wr_mode) begin
            mode_sel_reg <= {reg_wdata[7:5], 3'h3, reg_wdata[1:0]};
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            fail_mask_reg <= `RST_FAIL_MASK;
        end else if (wr_mask) begin
            fail_mask_reg <= reg_wdata;
        end
    end

    // read mux; registered below, so data follows the address a cycle later
    always @* begin
        rdata_next = 8'h00;
        case (reg_addr)
            `ADDR_BASE_MULT_HI: rdata_next = base_multiplier_reg[15:8];
            `ADDR_BASE_MULT_LO: rdata_next = base_multiplier_reg[7:0];
            `ADDR_FEC_B3: rdata_next = fec_numerator[15:8];
            `ADDR_FEC_B2: rdata_next = fec_numerator[7:0];
            `ADDR_FEC_B1: rdata_next = fec_denominator[15:8];
            `ADDR_FEC_B0: rdata_next = fec_denominator[7:0];
            `ADDR_FILTER_CTRL: rdata_next = filter_ctrl_reg;
            `ADDR_PRIO_23: rdata_next = prio_23_reg;
            `ADDR_PRIO_01: rdata_next = prio_01_reg;
            `ADDR_MODE_SEL: rdata_next = (operating_mode_select ==
                `MODE_AUTO) ? {sel_reg, mode_sel_reg[5:0]} :
                mode_sel_reg;
            `ADDR_FAIL_MASK: rdata_next = fail_mask_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    // product split over two stages to keep the multiplier path short
    always @(posedge ref_clk) begin
        if (rst) begin
            base_mult_prod_reg <= 32'h00000000;
        end else begin
            base_mult_prod_reg <= base_freq_value * base_multiplier_reg;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            phase_slope_cap <= 2'h3;
            phase_realign_enable <= 1'h0;
            bandwidth_code <= 8'h00;
            feedback_compensation_enable <= 1'h0;
            track_reference <= 1'h0;
            holdover_active <= 1'h0;
            freerun_active <= 1'h1;
            active_reference <= 2'h3;
            ref_three_freq_product <= 64'h0000000000000000;
        end else begin
            reg_rdata <= rdata_next;
            phase_slope_cap <= filter_ctrl_reg[3:2];
            phase_realign_enable <= filter_ctrl_reg[4];
            bandwidth_code <= (filter_ctrl_reg[7:5] == `BW_VARIABLE) ?
                variable_bandwidth_setting :
                {5'h00, filter_ctrl_reg[7:5]};
            // single shared feedback phase, loop source not checked
            feedback_compensation_enable <= mode_sel_reg[5];
            freerun_active <= operating_mode_select == `MODE_FREERUN;
            holdover_active <= hold_next;
            track_reference <= operating_mode_select != `MODE_FREERUN &&
                !hold_next;
            active_reference <= sel_next;
            // divide left to the loop; product keeps full precision
            ref_three_freq_product <= {32'h00000000, base_mult_prod_reg} *
                {48'h000000000000, fec_numerator};
        end
    end
endmodule // pll_reference_selector
`default_nettype wire

// ===== dv/ref_sel_properties.sv
// port assertions for the reference selector
`default_nettype none
module ref_sel_properties (
    // clock, reset, register port
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // loop controls
    input wire logic [1:0] phase_slope_cap,
    input wire logic phase_realign_enable,
    input wire logic [7:0] bandwidth_code,
    input wire logic feedback_compensation_enable,
    input wire logic track_reference,
    input wire logic holdover_active,
    input wire logic freerun_active,
    input wire logic [1:0] active_reference
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // write lands, then outputs follow one cycle later
    sequence wr_at(a);
        reg_wr && reg_addr == a;
    endsequence
    sequence wr_mode(m);
        reg_wr && reg_addr == 8'h33 && reg_wdata[1:0] == m;
    endsequence
    a_slope_follows: assert property (
        wr_at(8'h30) |-> ##2 phase_slope_cap == $past(reg_wdata[3:2], 2))
        else $error("slope cap mismatch");
    a_realign_follows: assert property (
        wr_at(8'h30) |-> ##2 phase_realign_enable == $past(reg_wdata[4], 2))
        else $error("realign mismatch");
    a_bw_fixed: assert property (
        reg_wr && reg_addr == 8'h30 && reg_wdata[7:5] != 3'h7 |->
        ##2 bandwidth_code[2:0] == $past(reg_wdata[7:5], 2))
        else $error("bandwidth code mismatch");
    a_fb_follows: assert property (
        wr_at(8'h33) |->
        ##2 feedback_compensation_enable == $past(reg_wdata[5], 2))
        else $error("feedback enable mismatch");
    a_freerun_mode: assert property (
        wr_mode(2'h0) |-> ##2 freerun_active && !track_reference &&
        !holdover_active)
        else $error("freerun state wrong");
    a_forced_holdover: assert property (
        wr_mode(2'h1) |-> ##2 holdover_active && !freerun_active)
        else $error("forced holdover state wrong");
    a_forced_choice: assert property (
        wr_mode(2'h2) ##2 track_reference |->
        active_reference == $past(reg_wdata[7:6], 2))
        else $error("forced reference wrong");
    a_unmapped_zero: assert property (
        reg_addr < 8'h2A || reg_addr > 8'h34 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule // ref_sel_properties
`default_nettype wire

// ===== dv/ref_monitor_model.sv
// reference monitor model driving per-reference failure flags
`default_nettype none
module ref_monitor_model (
    // requested failures, four bits per cause
    input wire logic [15:0] fail_req,
    // flags to the selector
    output logic [3:0] fail_signal_loss,
    output logic [3:0] fail_single_cycle_monitor,
    output logic [3:0] fail_coarse_frequency_monitor,
    output logic [3:0] fail_guard_soak_timer
);
    timeunit 1ns;
    timeprecision 1ps;
    // monitors run on other clocks, so flags move off the edge
    assign #3 {fail_guard_soak_timer, fail_coarse_frequency_monitor,
        fail_single_cycle_monitor, fail_signal_loss} = fail_req;
endmodule // ref_monitor_model
`default_nettype wire

// ===== dv/pll_reference_selector_tb_top.sv
// self-checking bench for the reference selector
`default_nettype none
module pll_reference_selector_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, rst = 1, reg_wr = 0, realign, fbc, trk, hold, free;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, vbw = 8'h00;
    logic [7:0] reg_rdata, bw;
    logic [15:0] base = 16'h0000, fail_req = 16'h0000;
    logic [3:0] f_los, f_scm, f_cfm, f_gst;
    logic [1:0] slope, act;
    logic [63:0] prod, e;
    int errors = 0, check_count = 0, cyc = 0;
    int mdl [int];
    initial forever #4 ref_clk = ~ref_clk;
    ref_monitor_model MON (.fail_req(fail_req), .fail_signal_loss(f_los),
        .fail_single_cycle_monitor(f_scm),
        .fail_coarse_frequency_monitor(f_cfm), .fail_guard_soak_timer(f_gst));
    pll_reference_selector DUT (.ref_clk(ref_clk), .rst(rst),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .fail_signal_loss(f_los),
        .fail_single_cycle_monitor(f_scm),
        .fail_coarse_frequency_monitor(f_cfm),
        .fail_guard_soak_timer(f_gst), .base_freq_value(base),
        .variable_bandwidth_setting(vbw), .phase_slope_cap(slope),
        .phase_realign_enable(realign), .bandwidth_code(bw),
        .feedback_compensation_enable(fbc), .track_reference(trk),
        .holdover_active(hold), .freerun_active(free),
        .active_reference(act), .ref_three_freq_product(prod));
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [63:0] x, s);
        check_count++;
        if (s !== x) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", n, x, s);
        end
    endtask
    function automatic int fix(input int a, d);
        // reserved bits read back fixed, not as written
        case (a)
            8'h30: return d & 8'hFC;
            8'h31, 8'h32: return d & 8'h77;
            8'h33: return (d & 8'hE3) | 8'h0C;
            default: return d;
        endcase
    endfunction
    task automatic wr(input logic [7:0] a, d);
        @(negedge ref_clk);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_wr = 0;
        mdl[a] = fix(a, d);
    endtask
    task automatic rd(input int a);
        @(negedge ref_clk);
        reg_addr = 8'(a);
        @(negedge ref_clk);
        cmp("rdata", mdl.exists(a) ? mdl[a] : 0, reg_rdata);
    endtask
    // failure flags pass a synchroniser, so allow settling time
    task automatic st(input logic t, h, f, input logic [1:0] r);
        repeat (8) @(negedge ref_clk);
        cmp("state", {t, h, f}, {trk, hold, free});
        if (t) cmp("ref", r, act);
    endtask
    task automatic reset_dut();
        rst = 1;
        repeat (12) @(negedge ref_clk);
        rst = 0;
        mdl = '{8'h2A: 8'h01, 8'h2B: 8'hE6, 8'h2C: 8'h00, 8'h2D: 8'h01,
            8'h2E: 8'h00, 8'h2F: 8'h01, 8'h30: 8'h0C, 8'h31: 8'h32,
            8'h32: 8'h10, 8'h33: 8'h0F, 8'h34: 8'h87};
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(62));
        base = 16'($urandom);
        reset_dut();
        for (int a = 8'h28; a <= 8'h35; a++) rd(a);
        $display("reset values done");
        for (int a = 8'h2A; a <= 8'h32; a++) wr(a, 8'($urandom));
        for (int a = 8'h2A; a <= 8'h32; a++) rd(a);
        e = base;
        e = e * (mdl[8'h2A] * 256 + mdl[8'h2B]) * (mdl[8'h2C] * 256 + mdl[8'h2D]);
        cmp("product", e, prod);
        $display("readback and product done");
        for (int c = 0; c < 8; c++) begin
            vbw = 8'($urandom);
            wr(8'h30, {c[2:0], c[0], c[1:0], 2'h0});
            repeat (2) @(negedge ref_clk);
            cmp("slope", c[1:0], slope);
            cmp("realign", c[0], realign);
            cmp("bw", c == 7 ? vbw : c, c == 7 ? bw : bw[2:0]);
        end
        wr(8'h30, 8'h0C);
        rd(8'h30);
        $display("filter control done");
        reset_dut();
        wr(8'h34, 8'hFF);
        st(1, 0, 0, 0);
        fail_req = 16'h0001;
        st(1, 0, 0, 1);
        fail_req = 16'h0000;
        st(1, 0, 0, 0);
        wr(8'h32, 8'h00);
        fail_req = 16'h0001;
        st(1, 0, 0, 1);
        fail_req = 16'h0000;
        st(1, 0, 0, 1);
        wr(8'h32, 8'h70);
        st(1, 0, 0, 0);
        fail_req = 16'h000F;
        st(0, 1, 0, 0);
        wr(8'h33, 8'h8E);
        st(0, 1, 0, 2);
        fail_req = 16'h000B;
        st(1, 0, 0, 2);
        rd(8'h33);
        fail_req = 16'h0004;
        st(0, 1, 0, 2);
        wr(8'h33, 8'h0D);
        st(0, 1, 0, 0);
        wr(8'h33, 8'h0C);
        st(0, 0, 1, 0);
        wr(8'h33, 8'h2F);
        st(1, 0, 0, 0);
        cmp("fb", 1, fbc);
        for (int i = 0; i < 2; i++) begin
            wr(8'h34, i ? 8'hF0 : 8'h0F);
            fail_req = 16'hFFFF;
            st(1, 0, 0, 0);
        end
        $display("selection done");
        end_of_test();
    end
endmodule // pll_reference_selector_tb_top
bind pll_reference_selector ref_sel_properties u_props (.ref_clk, .rst,
    .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .phase_slope_cap,
    .phase_realign_enable, .bandwidth_code, .feedback_compensation_enable,
    .track_reference, .holdover_active, .freerun_active, .active_reference);
`default_nettype wire
